// >>> logic/lss_regs.svh
// register map, bit positions and timing constants for line signaling status
`ifndef LSS_REGS_SVH
`define LSS_REGS_SVH

`define LSS_ADDR_SIG 8'h00
`define LSS_ADDR_SIGCLR 8'h04
`define LSS_ADDR_STAT 8'h08
`define LSS_ADDR_CLR 8'h0C
`define LSS_ADDR_EN 8'h10
`define LSS_ADDR_CFG 8'h14

`define LSS_B_HOOK 0
`define LSS_B_GNK 1
`define LSS_B_CID 2
`define LSS_B_CAD 3
`define LSS_B_IO2 4
`define LSS_B_THERMAL_ALARM 5
`define LSS_B_REGZ 6

`define LSS_SIG_RST 16'h0404
`define LSS_TYPEB 16'h0C0C
`define LSS_ZERO16 16'h0000
`define LSS_ONE16 16'h0001

`define LSS_CFG_OVP 0
`define LSS_CFG_RESP 1
`define LSS_CFG_RST 2'h0

`define LSS_CLK_MHZ 250
`define LSS_OC_NS 1000
`define LSS_OC_CYC 16'(((`LSS_OC_NS) * (`LSS_CLK_MHZ) + 999) / 1000)
`define LSS_RT_PERIODS 2'h2

`endif

// >>> logic/lss_pkg.sv
// types shared by the line signaling status block
package lss_pkg;

    typedef enum logic [2:0] {
        LSS_ST_DISCONNECT = 3'b000,
        LSS_ST_ACTIVE = 3'b001,
        LSS_ST_TIP_OPEN = 3'b010,
        LSS_ST_RING_OPEN = 3'b011,
        LSS_ST_BAL_RING = 3'b100,
        LSS_ST_UNBAL_RING = 3'b101,
        LSS_ST_IDLE = 3'b110,
        LSS_ST_SHUTDOWN = 3'b111
    } lss_sys_state_t;

    typedef struct packed {
        logic [11:0] long_current;
        logic [11:0] metallic_current;
        logic thermal_shutdown;
        logic cadence_off_phase;
        logic cadence_on_done;
        logic cid_ready;
        logic ring_period_tick;
        lss_sys_state_t sys_state;
    } lss_chan_sense_t;

    typedef struct packed {
        logic [11:0] ground_key_current_threshold;
        logic [15:0] ground_key_debounce_time;
        logic [11:0] switchhook_current_threshold;
        logic [15:0] switchhook_debounce_time;
        logic [11:0] ring_trip_current_threshold;
    } lss_chan_cfg_t;

endpackage

// >>> logic/lss_top.sv
// two-channel signaling status bank with interrupt logic
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/100ps
`include "lss_regs.svh"

// Notes on behaviour
// - regulator z fault reads condition, resets 0
// - fault from enabled overvoltage or sustained overcurrent
// - response bit zero: switcher off, shutdown
// - thermal alarm mirrors driver thermal shutdown
// - thermal alarm held while in disconnect
// - gpio two status mirrors pin level
// - masked cadence bit shows timer phase
// - unmasked cadence bit flags on period end
// - caller id bit: 0 full, 1 ready
// - caller id interrupt only on becoming ready
// - ground key debounced against threshold
// - hook bit: 0 on hook, 1 off
// - loop states use switchhook threshold, debounce
// - ringing states need two ring periods
// - unmasked level bit change or event flag rise raises interrupt outputs
// - plain read and clearing read of status
// - event flags cleared by clearing read
module lss_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // asynchronous pins
    input wire logic ovp_sense_z,
    input wire logic regulator_z_current_sense_input,
    input wire logic [1:0] gpio_two_pin,
    // per-channel sense and configuration
    input lss_pkg::lss_chan_sense_t chan_sense [2],
    input lss_pkg::lss_chan_cfg_t chan_cfg [2],
    // outputs
    output logic irq,
    output logic irq_n,
    output logic switcher_z_off,
    output logic force_shutdown
);

    logic [3:0] pin_s1_q;
    logic [3:0] pin_s2_q;
    logic [15:0] oc_cnt_q;
    logic regz_q;
    logic regz_d;
    logic [1:0] cfg_q;
    logic [15:0] en_q;
    logic [15:0] stat_q;
    logic [15:0] stat_d;
    logic [15:0] sig_q;
    logic [15:0] sig_d;
    logic [15:0] chg;
    logic [15:0] rdata_q;
    logic irq_q;
    logic irq_n_q;
    logic sw_off_q;
    logic shut_q;
    logic clr_rd;
    logic [7:0] sig_ch [2];

    // two-stage synchronisers for pin inputs
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
        end else begin
            pin_s1_q <= {gpio_two_pin, regulator_z_current_sense_input,
                ovp_sense_z};
            pin_s2_q <= pin_s1_q;
        end
    end

    // reading the clearing address also drops status and event flags
    assign clr_rd = reg_rd && (reg_addr == `LSS_ADDR_SIGCLR);

    // overcurrent must persist before it counts as a fault
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            oc_cnt_q <= `LSS_ZERO16;
        end else if (!pin_s2_q[1]) begin
            oc_cnt_q <= `LSS_ZERO16;
        end else if (oc_cnt_q < `LSS_OC_CYC) begin
            oc_cnt_q <= oc_cnt_q + `LSS_ONE16;
        end
    end

    assign regz_d = (cfg_q[`LSS_CFG_OVP] && pin_s2_q[0])
        || (oc_cnt_q >= `LSS_OC_CYC);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            regz_q <= 1'b0;
        end else begin
            regz_q <= regz_d;
        end
    end

    // automatic switcher shutdown, released by setting the response bit
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sw_off_q <= 1'b0;
            shut_q <= 1'b0;
        end else if (regz_d && !cfg_q[`LSS_CFG_RESP]) begin
            sw_off_q <= 1'b1;
            shut_q <= 1'b1;
        end else if (cfg_q[`LSS_CFG_RESP]) begin
            sw_off_q <= 1'b0;
            shut_q <= 1'b0;
        end
    end

    // per-channel status bits
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
            logic thermal_alarm_q;
            logic cad_flag_q;
            logic cid_flag_q;
            logic cid_prev_q;
            logic gnk_q;
            logic [15:0] gnk_cnt_q;
            logic hook_q;
            logic [15:0] hook_cnt_q;
            logic [1:0] ring_cnt_q;
            logic gk_cond;
            logic sh_cond;
            logic rt_cond;
            logic loop_st;
            logic ring_st;
            logic cad_en;
            logic cid_en;
            lss_pkg::lss_chan_sense_t s;
            lss_pkg::lss_chan_cfg_t c;

            assign s = chan_sense[ch];
            assign c = chan_cfg[ch];
            assign cad_en = en_q[ch * 8 + `LSS_B_CAD];
            assign cid_en = en_q[ch * 8 + `LSS_B_CID];
            assign gk_cond = s.long_current > c.ground_key_current_threshold;
            assign sh_cond =
                s.metallic_current > c.switchhook_current_threshold;
            assign rt_cond =
                s.metallic_current > c.ring_trip_current_threshold;
            assign loop_st = (s.sys_state == lss_pkg::LSS_ST_ACTIVE)
                || (s.sys_state == lss_pkg::LSS_ST_TIP_OPEN)
                || (s.sys_state == lss_pkg::LSS_ST_RING_OPEN);
            assign ring_st = (s.sys_state == lss_pkg::LSS_ST_BAL_RING)
                || (s.sys_state == lss_pkg::LSS_ST_UNBAL_RING);

            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    thermal_alarm_q <= 1'b0;
                end else if (s.sys_state != lss_pkg::LSS_ST_DISCONNECT) begin
                    thermal_alarm_q <= s.thermal_shutdown;
                end
            end

            // cadence event flag, set wins over the clearing read
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    cad_flag_q <= 1'b0;
                end else if (s.cadence_on_done) begin
                    cad_flag_q <= 1'b1;
                end else if (clr_rd || !cad_en) begin
                    cad_flag_q <= 1'b0;
                end
            end

            // caller id flag set on entering ready
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    cid_prev_q <= 1'b1;
                    cid_flag_q <= 1'b1;
                end else begin
                    cid_prev_q <= s.cid_ready;
                    if (!cid_en) begin
                        cid_flag_q <= s.cid_ready;
                    end else if (s.cid_ready && !cid_prev_q) begin
                        cid_flag_q <= 1'b1;
                    end else if (clr_rd) begin
                        cid_flag_q <= 1'b0;
                    end
                end
            end

            // ground key debounce
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    gnk_q <= 1'b0;
                    gnk_cnt_q <= `LSS_ZERO16;
                end else if (gk_cond == gnk_q) begin
                    gnk_cnt_q <= `LSS_ZERO16;
                end else if (gnk_cnt_q >= c.ground_key_debounce_time) begin
                    gnk_q <= gk_cond;
                    gnk_cnt_q <= `LSS_ZERO16;
                end else begin
                    gnk_cnt_q <= gnk_cnt_q + `LSS_ONE16;
                end
            end

            // hook detection depends on the system state
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    hook_q <= 1'b0;
                    hook_cnt_q <= `LSS_ZERO16;
                    ring_cnt_q <= 2'h0;
                end else if (loop_st) begin
                    ring_cnt_q <= 2'h0;
                    if (sh_cond == hook_q) begin
                        hook_cnt_q <= `LSS_ZERO16;
                    end else if (hook_cnt_q >= c.switchhook_debounce_time) begin
                        hook_q <= sh_cond;
                        hook_cnt_q <= `LSS_ZERO16;
                    end else begin
                        hook_cnt_q <= hook_cnt_q + `LSS_ONE16;
                    end
                end else if (ring_st) begin
                    hook_cnt_q <= `LSS_ZERO16;
                    if (rt_cond == hook_q) begin
                        ring_cnt_q <= 2'h0;
                    end else if (s.ring_period_tick) begin
                        if (ring_cnt_q + 2'h1 >= `LSS_RT_PERIODS) begin
                            hook_q <= rt_cond;
                            ring_cnt_q <= 2'h0;
                        end else begin
                            ring_cnt_q <= ring_cnt_q + 2'h1;
                        end
                    end
                end else begin
                    hook_cnt_q <= `LSS_ZERO16;
                    ring_cnt_q <= 2'h0;
                end
            end

            always_comb begin
                sig_ch[ch] = 8'h00;
                sig_ch[ch][`LSS_B_HOOK] = hook_q;
                sig_ch[ch][`LSS_B_GNK] = gnk_q;
                sig_ch[ch][`LSS_B_CID] = cid_flag_q;
                sig_ch[ch][`LSS_B_CAD] = cad_en ? cad_flag_q
                    : s.cadence_off_phase;
                sig_ch[ch][`LSS_B_IO2] = pin_s2_q[2 + ch];
                sig_ch[ch][`LSS_B_THERMAL_ALARM] = thermal_alarm_q;
                sig_ch[ch][`LSS_B_REGZ] = (ch == 1) ? regz_q : 1'b0;
            end
        end
    endgenerate

    assign sig_d = {sig_ch[1], sig_ch[0]};
    // event flags interrupt on rising only, others on any change
    assign chg = ((sig_d ^ sig_q) & ~`LSS_TYPEB)
        | (sig_d & ~sig_q & `LSS_TYPEB);

    // reset value shows both caller id buffers ready, so no false edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sig_q <= `LSS_SIG_RST;
        end else begin
            sig_q <= sig_d;
        end
    end

    // sticky status: a new event wins over a clear in the same cycle
    always_comb begin
        stat_d = stat_q;
        if (clr_rd) begin
            stat_d = `LSS_ZERO16;
        end else if (reg_wr && (reg_addr == `LSS_ADDR_CLR)) begin
            stat_d = stat_q & ~reg_wdata;
        end
        stat_d = stat_d | (chg & en_q);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stat_q <= `LSS_ZERO16;
        end else begin
            stat_q <= stat_d;
        end
    end

    // irq follows next status so it drops at the clearing read itself
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_q <= 1'b0;
            irq_n_q <= 1'b1;
        end else begin
            irq_q <= |(stat_d & en_q);
            irq_n_q <= ~(|(stat_d & en_q));
        end
    end

    // writable registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            en_q <= `LSS_ZERO16;
            cfg_q <= `LSS_CFG_RST;
        end else if (reg_wr) begin
            if (reg_addr == `LSS_ADDR_EN) begin
                en_q <= reg_wdata;
            end else if (reg_addr == `LSS_ADDR_CFG) begin
                cfg_q <= reg_wdata[1:0];
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_q <= `LSS_ZERO16;
        end else if (!reg_rd) begin
            rdata_q <= `LSS_ZERO16;
        end else if (reg_addr == `LSS_ADDR_SIG) begin
            rdata_q <= sig_q;
        end else if (reg_addr == `LSS_ADDR_SIGCLR) begin
            rdata_q <= sig_q;
        end else if (reg_addr == `LSS_ADDR_STAT) begin
            rdata_q <= stat_q;
        end else if (reg_addr == `LSS_ADDR_EN) begin
            rdata_q <= en_q;
        end else if (reg_addr == `LSS_ADDR_CFG) begin
            rdata_q <= {14'h0000, cfg_q};
        end else begin
            rdata_q <= `LSS_ZERO16;
        end
    end

    assign reg_rdata = rdata_q;
    assign irq = irq_q;
    assign irq_n = irq_n_q;
    assign switcher_z_off = sw_off_q;
    assign force_shutdown = shut_q;

endmodule

// >>> tb/lss_top_monitor.sv
// port checker for the signaling status bank, bound to its top
`timescale 1ns/100ps
module lss_top_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // pins and outputs
    input wire logic ovp_sense_z,
    input wire logic regulator_z_current_sense_input,
    input wire logic [1:0] gpio_two_pin,
    input wire logic irq,
    input wire logic irq_n,
    input wire logic switcher_z_off,
    input wire logic force_shutdown
);
    logic [8:0] oc_q;
    logic [8:0] ovp_q;
    logic [8:0] gp_q;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // cycles the two sense pins have been high and the gpio pins have held their level, saturating at 256
    always_ff @(posedge sys_clk) begin
        if (rst || !regulator_z_current_sense_input)
            oc_q <= 9'h000;
        else if (!oc_q[8])
            oc_q <= oc_q + 9'h001;
        if (rst || !ovp_sense_z)
            ovp_q <= 9'h000;
        else if (!ovp_q[8])
            ovp_q <= ovp_q + 9'h001;
        if (rst || !$stable(gpio_two_pin))
            gp_q <= 9'h000;
        else if (!gp_q[8])
            gp_q <= gp_q + 9'h001;
    end
    a_irq_pins: assert property (irq_n != irq)
        else $error("irq pins disagree");
    a_shut_pair: assert property (switcher_z_off == force_shutdown)
        else $error("shutdown outputs disagree");
    a_rdata_idle: assert property (!$past(reg_rd) |-> !reg_rdata)
        else $error("read data outside its cycle");
    a_resv_bits: assert property (reg_rd && reg_addr < 8'h08 |=>
        reg_rdata[7:6] == 2'h0 && !reg_rdata[15])
        else $error("unused status bits set");
    a_unmapped: assert property (reg_rd && reg_addr > 8'h14 |=>
        reg_rdata == 16'h0000) else $error("unmapped read not zero");
    a_mask_off: assert property (reg_wr && reg_addr == 8'h10 &&
        reg_wdata == 16'h0000 |-> ##2 !irq) else $error("irq while masked");
    a_reset_vals: assert property ($fell(rst) |-> !irq &&
        !switcher_z_off && reg_rdata == 16'h0000) else $error("reset values");
    a_gpio_mirror: assert property (reg_rd && reg_addr == 8'h00 &&
        gp_q > 9'h005 |=> reg_rdata[4] == $past(gpio_two_pin[0]) &&
        reg_rdata[12] == $past(gpio_two_pin[1])) else $error("gpio level");
    a_fault_delay: assert property ($rose(switcher_z_off) |->
        oc_q >= 9'h0FA || ovp_q > 9'h001) else $error("early shutdown");
endmodule

bind lss_top lss_top_chk u_chk (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ovp_sense_z(ovp_sense_z),
    .regulator_z_current_sense_input(regulator_z_current_sense_input),
    .gpio_two_pin(gpio_two_pin), .irq(irq), .irq_n(irq_n),
    .switcher_z_off(switcher_z_off), .force_shutdown(force_shutdown));

// >>> tb/lss_host_model.sv
// host side driver of the register port
`timescale 1ns/100ps
module lss_host_model (
    // clock
    input wire logic sys_clk,
    // register port
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // one-cycle strobe; the address picks plain or clearing read
    task automatic access(input logic w, input logic [7:0] a,
                          input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask
endmodule

// >>> tb/line_signaling_status_bench.sv
// self-checking bench for the signaling status bank
`timescale 1ns/100ps
module line_signaling_status_bench;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic reg_wr;
    logic reg_rd;
    logic ovp = 1'b0;
    logic ocs = 1'b0;
    logic irq;
    logic swoff;
    logic [1:0] gpio = 2'h0;
    logic [5:0] r;
    logic [31:0] e;
    logic rd_d = 1'b0;
    lss_pkg::lss_chan_sense_t sense [2];
    lss_pkg::lss_chan_cfg_t cfg [2];
    logic [31:0] exp_q [$];
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;
    always #2 sys_clk = ~sys_clk;
    lss_host_model u_host (.sys_clk(sys_clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
    lss_top u_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ovp_sense_z(ovp),
        .regulator_z_current_sense_input(ocs), .gpio_two_pin(gpio),
        .chan_sense(sense), .chan_cfg(cfg), .irq(irq), .irq_n(),
        .switcher_z_off(swoff), .force_shutdown());
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        n_compared++;
        if (seen !== want) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] m,
                      input logic [15:0] v);
        exp_q.push_back({m, v});
        u_host.access(1'b0, a, 16'h0000);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        u_host.access(1'b1, a, d);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic tick(input int c, input logic ring);
        @(posedge sys_clk);
        if (ring)
            sense[c].ring_period_tick <= 1'b1;
        else
            sense[c].cadence_on_done <= 1'b1;
        @(posedge sys_clk);
        sense[c].ring_period_tick <= 1'b0;
        sense[c].cadence_on_done <= 1'b0;
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // read data stand one cycle after the strobe
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (rd_d) begin
            e = exp_q.pop_front();
            chk(reg_rdata & e[31:16], e[15:0]);
        end
        rd_d <= reg_rd;
        if (cyc == 5000) begin
            n_fail++;
            results();
        end
    end
    initial begin
        foreach (sense[i]) begin
            sense[i] = '0;
            sense[i].cid_ready = 1'b1;
            cfg[i] = {12'h100, 16'h0014, 12'h100, 16'h0014, 12'h100};
        end
        void'($urandom(81));
        wait_n(6);
        rst <= 1'b0;
        rd(8'h00, 16'hFFFF, 16'h0404);
        rd(8'h08, 16'hFFFF, 16'h0000);
        rd(8'h1C, 16'hFFFF, 16'h0000);
        $display("reset test done");
        sense[0].sys_state <= lss_pkg::LSS_ST_ACTIVE;
        sense[1].sys_state <= lss_pkg::LSS_ST_ACTIVE;
        for (int i = 0; i < 8; i++) begin
            r = 6'($urandom());
            gpio <= r[1:0];
            sense[0].thermal_shutdown <= r[2];
            sense[1].thermal_shutdown <= r[3];
            sense[0].cadence_off_phase <= r[4];
            sense[1].cadence_off_phase <= r[5];
            wait_n(6);
            rd(8'h00, 16'h3838, {2'h0, r[3], r[1], r[5], 5'h0,
                r[2], r[0], r[4], 3'h0});
        end
        sense[0].sys_state <= lss_pkg::LSS_ST_DISCONNECT;
        wait_n(2);
        sense[0].thermal_shutdown <= !r[2];
        wait_n(6);
        rd(8'h00, 16'h0020, {10'h0, r[2], 5'h0});
        $display("level test done");
        sense[0].sys_state <= lss_pkg::LSS_ST_ACTIVE;
        sense[0].metallic_current <= 12'h200;
        sense[0].long_current <= 12'h200;
        wait_n(5);
        sense[0].metallic_current <= 12'h000;
        sense[0].long_current <= 12'h000;
        wait_n(30);
        rd(8'h00, 16'h0003, 16'h0000);
        for (int s = 1; s < 6; s++) begin
            sense[0].sys_state <= lss_pkg::lss_sys_state_t'(3'(s));
            sense[0].metallic_current <= s[0] ? 12'h200 : 12'h000;
            if (s < 4) begin
                sense[0].long_current <= s[0] ? 12'h200 : 12'h000;
                wait_n(30);
                rd(8'h00, 16'h0003, {14'h0, s[0], s[0]});
            end else begin
                tick(0, 1'b1);
                wait_n(4);
                rd(8'h00, 16'h0001, {15'h0, !s[0]});
                tick(0, 1'b1);
                wait_n(4);
                rd(8'h00, 16'h0001, {15'h0, s[0]});
            end
        end
        $display("hook test done");
        wr(8'h10, 16'h0808);
        tick(1, 1'b0);
        wait_n(4);
        chk(16'(irq), 16'h0001);
        rd(8'h08, 16'h0808, 16'h0800);
        rd(8'h00, 16'h0808, 16'h0800);
        rd(8'h04, 16'h0808, 16'h0800);
        wait_n(3);
        chk(16'(irq), 16'h0000);
        rd(8'h00, 16'h0808, 16'h0000);
        sense[1].cid_ready <= 1'b0;
        wait_n(4);
        rd(8'h00, 16'h0400, 16'h0000);
        sense[1].cid_ready <= 1'b1;
        wr(8'h10, 16'h0004);
        rd(8'h04, 16'h0404, 16'h0404);
        sense[0].cid_ready <= 1'b0;
        wait_n(4);
        chk(16'(irq), 16'h0000);
        sense[0].cid_ready <= 1'b1;
        wait_n(4);
        chk(16'(irq), 16'h0001);
        wr(8'h0C, 16'h0004);
        wait_n(2);
        chk(16'(irq), 16'h0000);
        rd(8'h08, 16'hFFFF, 16'h0000);
        rd(8'h04, 16'h0004, 16'h0004);
        rd(8'h00, 16'h0004, 16'h0000);
        rd(8'h10, 16'hFFFF, 16'h0004);
        wr(8'h10, 16'h0000);
        $display("event test done");
        ovp <= 1'b1;
        wait_n(8);
        rd(8'h00, 16'h4000, 16'h0000);
        chk(16'(swoff), 16'h0000);
        wr(8'h14, 16'h0001);
        wait_n(6);
        rd(8'h00, 16'h4000, 16'h4000);
        chk(16'(swoff), 16'h0001);
        ovp <= 1'b0;
        wr(8'h14, 16'h0003);
        rd(8'h14, 16'hFFFF, 16'h0003);
        wait_n(6);
        rd(8'h00, 16'h4000, 16'h0000);
        chk(16'(swoff), 16'h0000);
        wr(8'h14, 16'h0000);
        ocs <= 1'b1;
        wait_n(200);
        rd(8'h00, 16'h4000, 16'h0000);
        wait_n(60);
        rd(8'h00, 16'h4000, 16'h4000);
        chk(16'(swoff), 16'h0001);
        ocs <= 1'b0;
        wait_n(6);
        rd(8'h00, 16'h4000, 16'h0000);
        wait_n(3);
        $display("regulator test done");
        results();
    end
endmodule
